// file: rtl/io_regs_pkg.sv
// Package with the I/O-space register map, field layouts and bus carrier types.
package io_regs_pkg;

  // Register addresses in I/O space.
  localparam logic [15:0] ADDR_INTERRUPT_SOURCE_CONTROL = 16'hffec;
  localparam logic [15:0] ADDR_SYNC_PORT_DATA = 16'hfff0;
  localparam logic [15:0] ADDR_SYNC_PORT_CONTROL = 16'hfff1;
  localparam logic [15:0] ADDR_SYNC_PORT_STATUS = 16'hfff2;
  localparam logic [15:0] ADDR_SYNC_PORT_MULTICHANNEL = 16'hfff3;
  localparam logic [15:0] ADDR_ASYNC_PORT_DATA = 16'hfff4;
  localparam logic [15:0] ADDR_ASYNC_PORT_CONTROL = 16'hfff5;
  localparam logic [15:0] ADDR_PIN_AND_UART_STATUS = 16'hfff6;
  localparam logic [15:0] ADDR_BAUD_DIVISOR = 16'hfff7;
  localparam logic [15:0] ADDR_TIMER_CONTROL = 16'hfff8;
  localparam logic [15:0] ADDR_TIMER_PERIOD = 16'hfff9;
  localparam logic [15:0] ADDR_TIMER_COUNT = 16'hfffa;
  localparam logic [15:0] ADDR_SYNC_PORT_COUNTER = 16'hfffb;
  localparam logic [15:0] ADDR_WAIT_STATE_CONFIG = 16'hfffc;

  // Reset values.
  localparam logic [15:0] RST_INTERRUPT_SOURCE_CONTROL = 16'h0000;
  localparam logic [15:0] RST_SYNC_PORT_CONTROL = 16'h0030;
  localparam logic [15:0] RST_SYNC_PORT_STATUS = 16'h0000;
  localparam logic [15:0] RST_SYNC_PORT_MULTICHANNEL = 16'h0000;
  localparam logic [15:0] RST_ASYNC_PORT_CONTROL = 16'h0000;
  localparam logic [7:0] RST_UART_STATUS = 8'h18;
  localparam logic [15:0] RST_BAUD_DIVISOR = 16'h0001;
  localparam logic [15:0] RST_TIMER_PERIOD = 16'hffff;
  localparam logic [15:0] RST_TIMER_COUNT = 16'hffff;
  localparam logic [15:0] RST_SYNC_PORT_COUNTER = 16'h0000;
  localparam logic [11:0] RST_WAIT_STATE_CONFIG = 12'h0fff;
  localparam logic [3:0] RST_DIVIDE_RATIO = 4'h0;

  // Interrupt-source control fields.
  localparam int ICR_MODE_BIT = 0;
  localparam int ICR_FLAG_LSB = 1;
  localparam int ICR_MASK_LSB = 4;

  // Timer control fields.
  localparam int TCR_RATIO_LSB = 0;
  localparam int TCR_STOP_BIT = 4;
  localparam int TCR_RELOAD_BIT = 5;
  localparam int TCR_PRESCALE_LSB = 6;

  // Pin-and-UART status fields.
  localparam int PIN_LEVEL_LSB = 0;
  localparam int PIN_CHANGE_LSB = 4;
  localparam int UART_STATUS_LSB = 8;

  // CPU I/O-space access, one cycle wide.
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [15:0] wdata;
  } io_req_t;

  // Wait-state fields, laid out as in the configuration register.
  typedef struct packed {
    logic [2:0] io_space;
    logic [2:0] data_space;
    logic [2:0] prog_upper;
    logic [2:0] prog_lower;
  } wait_state_t;

endpackage

// file: rtl/peripheral_timer.sv
// Prescaled 16-bit down-counting timer with period reload.
module peripheral_timer #(
  parameter int RATIO_W = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic [RATIO_W-1:0] ratio_i,
  input wire logic stop_i,
  input wire logic reload_i,
  input wire logic [15:0] period_i,
  input wire logic count_we_i,
  input wire logic [15:0] count_wdata_i,
  // State
  output logic [15:0] count_o,
  output logic [RATIO_W-1:0] prescale_o,
  output logic borrow_o
);

  logic step;

  assign step = !stop_i && (prescale_o == '0);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      prescale_o <= RATIO_W'(io_regs_pkg::RST_DIVIDE_RATIO);
    end else if (reload_i || step || stop_i == 1'b0 && prescale_o == '0) begin
      prescale_o <= ratio_i;
    end else if (!stop_i) begin
      prescale_o <= prescale_o - 1'b1;
    end
  end

  // Reload wins over a software write, which wins over counting.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      count_o <= io_regs_pkg::RST_TIMER_COUNT;
      borrow_o <= 1'b0;
    end else begin
      borrow_o <= 1'b0;
      if (reload_i) begin
        count_o <= period_i;
      end else if (count_we_i) begin
        count_o <= count_wdata_i;
      end else if (step) begin
        if (count_o == 16'h0000) begin
          count_o <= period_i;
          borrow_o <= 1'b1;
        end else begin
          count_o <= count_o - 16'h0001;
        end
      end
    end
  end

  chk_borrow_reloads: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    step && !reload_i && !count_we_i && count_o == 16'h0000
    |=> borrow_o && count_o == $past(period_i)) else $error("borrow did not reload");

  chk_reload_loads: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    reload_i |=> count_o == $past(period_i) && prescale_o == $past(ratio_i))
    else $error("reload did not load period");

  chk_timer_reset: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> count_o == 16'hffff && prescale_o == '0)
    else $error("timer reset values wrong");

  chk_stop_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    stop_i && !reload_i && !count_we_i |=> count_o == $past(count_o))
    else $error("stopped timer moved");

  cov_timer_borrow: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) borrow_o);

endmodule // peripheral_timer

// file: rtl/io_space_peripheral_register_bank.sv
// I/O-space register bank for the on-chip peripherals of a DSP.
module io_space_peripheral_register_bank #(
  parameter int PIN_COUNT = 4,
  parameter int RATIO_W = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // CPU I/O-space access
  input wire io_regs_pkg::io_req_t io_req_i,
  output logic [15:0] io_rdata_o,
  // Shared external interrupt pins, active low
  input wire logic ext_int_one_n_i,
  input wire logic ext_int_two_n_i,
  input wire logic ext_int_three_n_i,
  // Interrupt and bus-yield requests
  output logic bus_yield_request_o,
  output logic int_one_request_o,
  output logic int_two_three_request_o,
  output logic timer_borrow_o,
  // General-purpose pins
  input wire logic [PIN_COUNT-1:0] general_purpose_pins_i,
  output logic [PIN_COUNT-1:0] general_purpose_pins_o,
  output logic [PIN_COUNT-1:0] general_purpose_pins_oe_o,
  // UART side
  input wire logic [7:0] uart_status_i,
  output logic [15:0] baud_divisor_o,
  output logic uart_enable_o,
  output logic [15:0] async_port_control_o,
  // Sync port side
  output logic [15:0] sync_port_control_o,
  // Wait-state generator settings
  output io_regs_pkg::wait_state_t wait_state_config_o
);

  // Decode of one register write.
  logic wr_icr, wr_sdata, wr_scon, wr_sstat, wr_smc, wr_adata, wr_acon;
  logic wr_pins, wr_baud, wr_tcon, wr_per, wr_cnt, wr_sctr, wr_wait;

  always_comb begin
    wr_icr = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_INTERRUPT_SOURCE_CONTROL;
    wr_sdata = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_SYNC_PORT_DATA;
    wr_scon = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_SYNC_PORT_CONTROL;
    wr_sstat = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_SYNC_PORT_STATUS;
    wr_smc = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_SYNC_PORT_MULTICHANNEL;
    wr_adata = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_ASYNC_PORT_DATA;
    wr_acon = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_ASYNC_PORT_CONTROL;
    wr_pins = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_PIN_AND_UART_STATUS;
    wr_baud = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_BAUD_DIVISOR;
    wr_tcon = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_TIMER_CONTROL;
    wr_per = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_TIMER_PERIOD;
    wr_cnt = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_TIMER_COUNT;
    wr_sctr = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_SYNC_PORT_COUNTER;
    wr_wait = io_req_i.wr && io_req_i.addr == io_regs_pkg::ADDR_WAIT_STATE_CONFIG;
  end

  // Pin synchronisers; stage one feeds only stage two.
  logic [2:0] int_meta, int_sync, int_prev;
  logic [PIN_COUNT-1:0] pin_meta, pin_sync, pin_prev;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      int_meta <= 3'h7;
      int_sync <= 3'h7;
      int_prev <= 3'h7;
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      int_meta <= {ext_int_three_n_i, ext_int_two_n_i, ext_int_one_n_i};
      int_sync <= int_meta;
      int_prev <= int_sync;
      pin_meta <= general_purpose_pins_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Interrupt-source control: mode bit, three sticky flags, three masks.
  logic icr_mode;
  logic [2:0] icr_flag, icr_mask, int_fall, flag_set, flag_clr;

  assign int_fall = int_prev & ~int_sync;
  // Interrupt one only latches as an interrupt while the pin is not a bus-yield request.
  assign flag_set = {int_fall[2:1], int_fall[0] & icr_mode};
  assign flag_clr = wr_icr ? io_req_i.wdata[io_regs_pkg::ICR_FLAG_LSB +: 3] : 3'h0;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      icr_mode <= io_regs_pkg::RST_INTERRUPT_SOURCE_CONTROL[io_regs_pkg::ICR_MODE_BIT];
      icr_mask <= io_regs_pkg::RST_INTERRUPT_SOURCE_CONTROL[io_regs_pkg::ICR_MASK_LSB +: 3];
    end else if (wr_icr) begin
      icr_mode <= io_req_i.wdata[io_regs_pkg::ICR_MODE_BIT];
      icr_mask <= io_req_i.wdata[io_regs_pkg::ICR_MASK_LSB +: 3];
    end
  end

  // A new edge in the same cycle as a clear keeps the flag set.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      icr_flag <= io_regs_pkg::RST_INTERRUPT_SOURCE_CONTROL[io_regs_pkg::ICR_FLAG_LSB +: 3];
    end else begin
      icr_flag <= (icr_flag & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bus_yield_request_o <= 1'b0;
      int_one_request_o <= 1'b0;
      int_two_three_request_o <= 1'b0;
    end else begin
      bus_yield_request_o <= !icr_mode && !int_sync[0];
      int_one_request_o <= icr_flag[0] && icr_mask[0];
      int_two_three_request_o <= |(icr_flag[2:1] & icr_mask[2:1]);
    end
  end

  // Serial data holders carry no reset, as software may not rely on them.
  logic [15:0] sync_data, async_data;

  always_ff @(posedge sys_clk_i) begin
    if (wr_sdata) begin
      sync_data <= io_req_i.wdata;
    end
    if (wr_adata) begin
      async_data <= io_req_i.wdata;
    end
  end

  // Plain control registers of the serial ports and wait-state generator.
  logic [15:0] sync_status, sync_multichannel, sync_counter;
  logic [11:0] wait_bits;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sync_port_control_o <= io_regs_pkg::RST_SYNC_PORT_CONTROL;
      sync_status <= io_regs_pkg::RST_SYNC_PORT_STATUS;
      sync_multichannel <= io_regs_pkg::RST_SYNC_PORT_MULTICHANNEL;
      sync_counter <= io_regs_pkg::RST_SYNC_PORT_COUNTER;
      async_port_control_o <= io_regs_pkg::RST_ASYNC_PORT_CONTROL;
      wait_bits <= io_regs_pkg::RST_WAIT_STATE_CONFIG;
    end else begin
      if (wr_scon) begin
        sync_port_control_o <= io_req_i.wdata;
      end
      if (wr_sstat) begin
        sync_status <= io_req_i.wdata;
      end
      if (wr_smc) begin
        sync_multichannel <= io_req_i.wdata;
      end
      if (wr_sctr) begin
        sync_counter <= io_req_i.wdata;
      end
      if (wr_acon) begin
        async_port_control_o <= io_req_i.wdata;
      end
      if (wr_wait) begin
        wait_bits <= io_req_i.wdata[11:0];
      end
    end
  end

  assign wait_state_config_o = wait_bits;
  assign general_purpose_pins_oe_o = async_port_control_o[PIN_COUNT-1:0];

  // Pin-and-UART status: levels, sticky change flags on inputs, UART status byte.
  logic [PIN_COUNT-1:0] pin_change;
  logic [7:0] uart_status;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      general_purpose_pins_o <= '0;
      uart_status <= io_regs_pkg::RST_UART_STATUS;
    end else begin
      uart_status <= uart_status_i;
      if (wr_pins) begin
        general_purpose_pins_o <= io_req_i.wdata[io_regs_pkg::PIN_LEVEL_LSB +: PIN_COUNT];
      end
    end
  end

  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin_change
    logic clr;
    logic set;
    assign clr = wr_pins && io_req_i.wdata[io_regs_pkg::PIN_CHANGE_LSB + g];
    assign set = !general_purpose_pins_oe_o[g] && (pin_sync[g] != pin_prev[g]);
    always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
        pin_change[g] <= 1'b0;
      end else begin
        pin_change[g] <= (pin_change[g] && !clr) || set;
      end
    end
  end

  // Baud divisor; zero stalls the UART entirely.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      baud_divisor_o <= io_regs_pkg::RST_BAUD_DIVISOR;
      uart_enable_o <= 1'b0;
    end else begin
      if (wr_baud) begin
        baud_divisor_o <= io_req_i.wdata;
      end
      uart_enable_o <= baud_divisor_o != 16'h0000;
    end
  end

  // Timer control and period.
  logic [RATIO_W-1:0] timer_ratio, timer_prescale;
  logic timer_stop, timer_reload;
  logic [15:0] timer_period, timer_count;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      timer_ratio <= RATIO_W'(io_regs_pkg::RST_DIVIDE_RATIO);
      timer_stop <= 1'b0;
      timer_period <= io_regs_pkg::RST_TIMER_PERIOD;
    end else begin
      if (wr_tcon) begin
        timer_ratio <= io_req_i.wdata[io_regs_pkg::TCR_RATIO_LSB +: RATIO_W];
        timer_stop <= io_req_i.wdata[io_regs_pkg::TCR_STOP_BIT];
      end
      if (wr_per) begin
        timer_period <= io_req_i.wdata;
      end
    end
  end

  // The reload bit acts on the write and never reads back as one.
  assign timer_reload = wr_tcon && io_req_i.wdata[io_regs_pkg::TCR_RELOAD_BIT];

  peripheral_timer #(
    .RATIO_W(RATIO_W)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ratio_i(timer_ratio),
    .stop_i(timer_stop),
    .reload_i(timer_reload),
    .period_i(timer_period),
    .count_we_i(wr_cnt),
    .count_wdata_i(io_req_i.wdata),
    .count_o(timer_count),
    .prescale_o(timer_prescale),
    .borrow_o(timer_borrow_o)
  );

  // Read mux; unmapped addresses and unused bits return zero.
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    case (io_req_i.addr)
      io_regs_pkg::ADDR_INTERRUPT_SOURCE_CONTROL: begin
        next_rdata[io_regs_pkg::ICR_MODE_BIT] = icr_mode;
        next_rdata[io_regs_pkg::ICR_FLAG_LSB +: 3] = icr_flag;
        next_rdata[io_regs_pkg::ICR_MASK_LSB +: 3] = icr_mask;
      end
      io_regs_pkg::ADDR_SYNC_PORT_DATA: next_rdata = sync_data;
      io_regs_pkg::ADDR_SYNC_PORT_CONTROL: next_rdata = sync_port_control_o;
      io_regs_pkg::ADDR_SYNC_PORT_STATUS: next_rdata = sync_status;
      io_regs_pkg::ADDR_SYNC_PORT_MULTICHANNEL: next_rdata = sync_multichannel;
      io_regs_pkg::ADDR_ASYNC_PORT_DATA: next_rdata = async_data;
      io_regs_pkg::ADDR_ASYNC_PORT_CONTROL: next_rdata = async_port_control_o;
      io_regs_pkg::ADDR_PIN_AND_UART_STATUS: begin
        next_rdata[io_regs_pkg::PIN_LEVEL_LSB +: PIN_COUNT] = pin_sync;
        next_rdata[io_regs_pkg::PIN_CHANGE_LSB +: PIN_COUNT] = pin_change;
        next_rdata[io_regs_pkg::UART_STATUS_LSB +: 8] = uart_status;
      end
      io_regs_pkg::ADDR_BAUD_DIVISOR: next_rdata = baud_divisor_o;
      io_regs_pkg::ADDR_TIMER_CONTROL: begin
        next_rdata[io_regs_pkg::TCR_RATIO_LSB +: RATIO_W] = timer_ratio;
        next_rdata[io_regs_pkg::TCR_STOP_BIT] = timer_stop;
        next_rdata[io_regs_pkg::TCR_PRESCALE_LSB +: RATIO_W] = timer_prescale;
      end
      io_regs_pkg::ADDR_TIMER_PERIOD: next_rdata = timer_period;
      io_regs_pkg::ADDR_TIMER_COUNT: next_rdata = timer_count;
      io_regs_pkg::ADDR_SYNC_PORT_COUNTER: next_rdata = sync_counter;
      io_regs_pkg::ADDR_WAIT_STATE_CONFIG: next_rdata[11:0] = wait_bits;
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      io_rdata_o <= 16'h0000;
    end else if (io_req_i.rd) begin
      io_rdata_o <= next_rdata;
    end else begin
      io_rdata_o <= 16'h0000;
    end
  end

  chk_icr_reset: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> icr_mode == 1'b0 && icr_flag == 3'h0 && icr_mask == 3'h0)
    else $error("interrupt-source control not cleared by reset");

  chk_reset_values: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> sync_port_control_o == 16'h0030 && wait_bits == 12'hfff
    && baud_divisor_o == 16'h0001 && timer_period == 16'hffff)
    else $error("reset value wrong");

  chk_flag_set_wins: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    flag_set[1] && flag_clr[1] |=> icr_flag[1])
    else $error("flag set lost against clear");

  chk_yield_steer: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !icr_mode && !int_sync[0] |=> bus_yield_request_o ##0 !$past(flag_set[0]))
    else $error("bus-yield steering wrong");

  chk_baud_zero_stops: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_baud && io_req_i.wdata == 16'h0000 ##1 !wr_baud |=> !uart_enable_o)
    else $error("uart enabled with zero divisor");

  chk_unmapped_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    io_req_i.rd && (io_req_i.addr < io_regs_pkg::ADDR_INTERRUPT_SOURCE_CONTROL
    || io_req_i.addr inside {[16'hffed:16'hffef], [16'hfffd:16'hffff]})
    |=> io_rdata_o == 16'h0000) else $error("unmapped read not zero");

  chk_wait_top_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    io_req_i.rd && io_req_i.addr == io_regs_pkg::ADDR_WAIT_STATE_CONFIG
    |=> io_rdata_o[15:12] == 4'h0 && io_rdata_o[11:0] == $past(wait_bits))
    else $error("wait-state read wrong");

  chk_pin_change: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !general_purpose_pins_oe_o[0] && pin_sync[0] != pin_prev[0] |=> pin_change[0])
    else $error("input change not flagged");

  cov_icr_flag: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) int_two_three_request_o);
  cov_yield: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) bus_yield_request_o);
  cov_reload: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) timer_reload);

endmodule // io_space_peripheral_register_bank

// file: tb/io_space_peripheral_register_bank_tb.sv
// Self-checking testbench for the I/O-space peripheral register bank.
module io_space_peripheral_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  io_regs_pkg::io_req_t io_req = '0;
  logic int_one_n = 1'b1;
  logic int_two_n = 1'b1;
  logic int_three_n = 1'b1;
  logic [3:0] pins_in = 4'h0;
  logic [7:0] uart_status = 8'h18;
  logic [15:0] io_rdata, baud_div, async_ctrl, sync_ctrl, d;
  logic [3:0] pins_out, pins_oe;
  logic yield_req, int_one_req, int_two_three_req, borrow, uart_en;
  io_regs_pkg::wait_state_t ws;
  int miscompares = 0;
  int n_checks = 0;

  always #20 sys_clk = ~sys_clk;

  io_space_peripheral_register_bank DUT (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .io_req_i(io_req), .io_rdata_o(io_rdata),
    .ext_int_one_n_i(int_one_n), .ext_int_two_n_i(int_two_n), .ext_int_three_n_i(int_three_n),
    .bus_yield_request_o(yield_req), .int_one_request_o(int_one_req),
    .int_two_three_request_o(int_two_three_req), .timer_borrow_o(borrow),
    .general_purpose_pins_i(pins_in), .general_purpose_pins_o(pins_out),
    .general_purpose_pins_oe_o(pins_oe), .uart_status_i(uart_status),
    .baud_divisor_o(baud_div), .uart_enable_o(uart_en), .async_port_control_o(async_ctrl),
    .sync_port_control_o(sync_ctrl), .wait_state_config_o(ws));

  task automatic close_out();
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask

  // One access every two cycles, so no request field is driven twice in a time step.
  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] wd);
    @(posedge sys_clk);
    #1;
    io_req.addr = a;
    io_req.wr = wr;
    io_req.rd = ~wr;
    io_req.wdata = wd;
    @(posedge sys_clk);
    #1;
    d = io_rdata;
    io_req.rd = 1'b0;
    io_req.wr = 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [15:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    check(name, d, exp);
  endtask

  // Bounded wait on a design flag; running out of cycles ends the run as a failure.
  task automatic wait_for(input int sel);
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      #1;
      if ((sel == 0 && yield_req === 1'b1) || (sel == 1 && int_two_three_req === 1'b1) ||
          (sel == 2 && borrow === 1'b1)) return;
    end
    miscompares++;
    close_out();
  endtask

  task automatic reset_values();
    logic [15:0] addrs [10] = '{16'hffec, 16'hfff1, 16'hfff2, 16'hfff3, 16'hfff5, 16'hfff7,
                                16'hfff8, 16'hfff9, 16'hfffb, 16'hfffc};
    logic [15:0] exps [10] = '{16'h0000, 16'h0030, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
                               16'h0000, 16'hffff, 16'h0000, 16'h0fff};
    check("wait_cfg_out", {4'h0, ws}, 16'h0fff);
    check("sync_ctrl_out", sync_ctrl, 16'h0030);
    for (int i = 0; i < 10; i++) rd_chk("reset_value", addrs[i], exps[i]);
    rd_chk("pin_status_reset", 16'hfff6, 16'h1800);
    acc(1'b0, 16'hfffa, 16'h0000);
    check("count_near_all_ones", {15'h0, d > 16'hff00}, 16'h0001);
    check("uart_enable_reset", {15'h0, uart_en}, 16'h0001);
  endtask

  task automatic map_and_unused();
    acc(1'b1, 16'hfffc, 16'hffff);
    rd_chk("wait_cfg_top_bits", 16'hfffc, 16'h0fff);
    acc(1'b1, 16'hfffc, 16'h0a5c);
    check("wait_cfg_data_field", {13'h0, ws.data_space}, 16'h0001);
    check("wait_cfg_io_field", {13'h0, ws.io_space}, 16'h0005);
    acc(1'b1, 16'hffee, 16'h1234);
    rd_chk("unmapped_read", 16'hffee, 16'h0000);
    rd_chk("unmapped_gap", 16'hfffd, 16'h0000);
  endtask

  task automatic plain_regs();
    logic [15:0] addrs [6] = '{16'hfff0, 16'hfff1, 16'hfff2, 16'hfff3, 16'hfff4, 16'hfffb};
    logic [15:0] vals [6] = '{16'h1234, 16'h2345, 16'h3456, 16'h4567, 16'h5678, 16'h6789};
    for (int i = 0; i < 6; i++) acc(1'b1, addrs[i], vals[i]);
    for (int i = 0; i < 6; i++) rd_chk("plain_reg", addrs[i], vals[i]);
    check("sync_ctrl_written", sync_ctrl, 16'h2345);
    @(posedge sys_clk);
    #1;
    check("rdata_one_cycle", io_rdata, 16'h0000);
  endtask

  task automatic baud_zero();
    acc(1'b1, 16'hfff7, 16'h0000);
    check("baud_out", baud_div, 16'h0000);
    @(posedge sys_clk);
    #1;
    check("uart_off", {15'h0, uart_en}, 16'h0000);
    acc(1'b1, 16'hfff7, 16'h0005);
    @(posedge sys_clk);
    #1;
    check("uart_on", {15'h0, uart_en}, 16'h0001);
  endtask

  task automatic timer_reload();
    acc(1'b1, 16'hfff8, 16'h0012);
    acc(1'b0, 16'hfff8, 16'h0000);
    check("timer_ctrl_fields", d & 16'h003f, 16'h0012);
    acc(1'b1, 16'hfff9, 16'h0003);
    acc(1'b1, 16'hfff8, 16'h0030);
    rd_chk("count_after_reload", 16'hfffa, 16'h0003);
    acc(1'b0, 16'hfff8, 16'h0000);
    check("reload_reads_zero", d & 16'h003f, 16'h0010);
    acc(1'b1, 16'hfffa, 16'h0002);
    rd_chk("count_write", 16'hfffa, 16'h0002);
    acc(1'b1, 16'hfff8, 16'h0000);
    wait_for(2);
    acc(1'b1, 16'hfff8, 16'h0010);
    acc(1'b0, 16'hfffa, 16'h0000);
    check("count_reloaded", {15'h0, d <= 16'h0003}, 16'h0001);
  endtask

  task automatic interrupts();
    int_one_n = 1'b0;
    wait_for(0);
    check("int_one_in_yield_mode", {15'h0, int_one_req}, 16'h0000);
    int_one_n = 1'b1;
    acc(1'b1, 16'hffec, 16'h0071);
    int_two_n = 1'b0;
    wait_for(1);
    int_two_n = 1'b1;
    rd_chk("int_two_flag", 16'hffec, 16'h0075);
    acc(1'b1, 16'hffec, 16'h0075);
    rd_chk("int_two_cleared", 16'hffec, 16'h0071);
    check("int_two_three_req_low", {15'h0, int_two_three_req}, 16'h0000);
    // The pin edge reaches the flag on the same edge that takes the clearing write.
    int_two_n = 1'b0;
    @(posedge sys_clk);
    acc(1'b1, 16'hffec, 16'h0075);
    int_two_n = 1'b1;
    rd_chk("set_beats_clear", 16'hffec, 16'h0075);
    acc(1'b1, 16'hffec, 16'h0075);
    int_three_n = 1'b0;
    int_one_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    int_three_n = 1'b1;
    int_one_n = 1'b1;
    rd_chk("int_one_three_flags", 16'hffec, 16'h007b);
    check("int_one_req_high", {15'h0, int_one_req}, 16'h0001);
    check("int_two_three_req_high", {15'h0, int_two_three_req}, 16'h0001);
    check("no_yield_in_int_mode", {15'h0, yield_req}, 16'h0000);
  endtask

  task automatic pins();
    pins_in = 4'h5;
    repeat (6) @(posedge sys_clk);
    rd_chk("pin_levels_changes", 16'hfff6, 16'h1855);
    acc(1'b1, 16'hfff6, 16'h005a);
    check("pins_driven", {12'h0, pins_out}, 16'h000a);
    uart_status = 8'h24;
    rd_chk("pin_flags_cleared", 16'hfff6, 16'h2405);
    acc(1'b1, 16'hfff5, 16'h000f);
    check("pins_enable", {12'h0, pins_oe}, 16'h000f);
    check("async_ctrl_out", async_ctrl, 16'h000f);
    pins_in = 4'h0;
    repeat (6) @(posedge sys_clk);
    rd_chk("outputs_not_flagged", 16'hfff6, 16'h2400);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    reset_values();
    map_and_unused();
    plain_regs();
    baud_zero();
    timer_reload();
    interrupts();
    pins();
    close_out();
  end
endmodule // io_space_peripheral_register_bank_tb
